/* File: hw/rsm_pkg.sv */
// Shared constants and types for the ring shared-memory node.
package rsm_pkg;
	localparam int ADDR_W = 28;
	localparam int DWA_W = 26;
	localparam int ID_W = 8;
	localparam int ENTRY_W = ID_W + DWA_W + 32;
	localparam int PKT_MAX_WORDS = 16;
	localparam int LEN_W = 4;
	localparam int HDR_ORIG_LSB = 24;
	localparam logic [1:0] BAR_LCFG_MEM = 2'h0;
	localparam logic [1:0] BAR_LCFG_IO = 2'h1;
	localparam logic [1:0] BAR_NODE = 2'h2;
	localparam logic [1:0] BAR_SHMEM = 2'h3;
	localparam logic [27:0] MEM_TOP_128 = 28'h7ffffff;
	localparam logic [27:0] MEM_TOP_256 = 28'hfffffff;
	localparam logic [27:0] SHM_RESERVED_TOP = 28'h000003f;
	localparam logic [7:0] OFS_INTERRUPT_CONTROL_STATE = 8'h68;
	localparam logic [7:0] OFS_NODE_ID = 8'h04;
	localparam logic [7:0] OFS_LOCAL_CTRL_STATUS_FIRST = 8'h08;
	localparam logic [7:0] OFS_SECONDARY_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_SECONDARY_IRQ_ENABLE = 8'h14;
	localparam int IC_PCI_EN = 8;
	localparam int IC_LINT_EN = 11;
	localparam int IC_LINT_ACT = 15;
	localparam int IC_DMA_EN = 18;
	localparam int IC_DMA_DONE = 21;
	localparam logic [31:0] INTERRUPT_CONTROL_STATE_RST = 32'h0000_0000;
	localparam logic [31:0] INTERRUPT_CONTROL_STATE_WMASK = 32'h0004_0900;
	localparam int LC_LED = 31;
	localparam int LC_SIGDET = 0;
	localparam int LC_SYNC = 1;
	localparam int LC_LINK_OK = 2;
	localparam logic LED_RST = 1'b1;
	localparam int LI_OWN = 0;
	localparam int LI_LINKDN = 1;
	localparam int LI_RXERR = 2;
	localparam int LI_NET_LSB = 8;
	localparam int NET_IRQ_N = 5;
	localparam logic [31:0] SECONDARY_IRQ_STATUS_RST = 32'h0000_0000;
	localparam logic [31:0] SECONDARY_IRQ_ENABLE_RST = 32'h0000_0000;
	localparam logic [31:0] SECONDARY_IRQ_STATUS_USED = 32'h0000_1f07;
	typedef enum {T_IDLE, T_GATHER, T_HDR0, T_HDR1, T_DATA, T_CHK} rsm_tx_state_t;
	typedef enum {R_IDLE, R_HDR1, R_DATA, R_DRAIN} rsm_rx_state_t;
endpackage

/* File: hw/rsm_sync3.sv */
// Three-stage synchroniser with agreement filter for a pin input.
`timescale 1ns/1ps
module rsm_sync3 (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic pin_in,
	output logic level_out
);
	logic ff1_reg, ff2_reg, ff3_reg;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ff1_reg <= 1'b0;
			ff2_reg <= 1'b0;
			ff3_reg <= 1'b0;
			level_out <= 1'b0;
		end else begin
			ff1_reg <= pin_in;
			ff2_reg <= ff1_reg;
			ff3_reg <= ff2_reg;
			if (ff2_reg == ff3_reg) begin
				level_out <= ff3_reg;
			end
		end
	end
endmodule

/* File: hw/rsm_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module rsm_fifo #(
	parameter int W = 66,
	parameter int D = 16
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	input wire logic [W-1:0] wr_data_in,
	output logic rd_valid_out,
	input wire logic rd_ready_in,
	output logic [W-1:0] rd_data_out
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_reg [D];
	logic [AW-1:0] wp_reg, rp_reg;
	logic [AW:0] cnt_reg;
	logic do_wr, do_rd;

	if (D < 2 || (D & (D - 1)) != 0) begin : g_chk
		$error("rsm_fifo depth must be a power of two of at least 2");
	end

	assign wr_ready_out = (cnt_reg != (AW + 1)'(D));
	assign rd_valid_out = (cnt_reg != '0);
	assign rd_data_out = mem_reg[rp_reg];
	assign do_wr = wr_valid_in && wr_ready_out;
	assign do_rd = rd_ready_in && rd_valid_out;

	always_ff @(posedge mclk_in) begin
		if (do_wr) begin
			mem_reg[wp_reg] <= wr_data_in;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (do_wr) begin
				wp_reg <= wp_reg + 1'b1;
			end
			if (do_rd) begin
				rp_reg <= rp_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
		end
	end
endmodule

/* File: hw/rsm_node.sv */
// One node of the replicated shared-memory ring: host side, SDRAM, packet link, LEDs, interrupts.
`timescale 1ns/1ps
module rsm_node #(
	parameter int MEM_MB = 128,
	parameter int TXF_DEPTH = 16,
	parameter int RXF_DEPTH = 16
) (
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] node_id_in,
	input wire logic host_req_in,
	input wire logic [1:0] host_bar_in,
	input wire logic host_wr_in,
	input wire logic host_dma_in,
	input wire logic [27:0] host_addr_in,
	input wire logic [31:0] host_wdata_in,
	output logic host_ack_out,
	output logic [31:0] host_rdata_out,
	input wire logic dma_done_in,
	input wire logic [4:0] net_irq_in,
	output logic sdram_wr_out,
	output logic sdram_rd_out,
	output logic [25:0] sdram_addr_out,
	output logic [31:0] sdram_wdata_out,
	input wire logic [31:0] sdram_rdata_in,
	input wire logic sig_det_in,
	input wire logic sync_in,
	output logic tx_valid_out,
	output logic tx_sop_out,
	output logic tx_eop_out,
	output logic [31:0] tx_data_out,
	input wire logic tx_ready_in,
	input wire logic rx_valid_in,
	input wire logic rx_sop_in,
	input wire logic rx_eop_in,
	input wire logic [31:0] rx_data_in,
	output logic rx_ready_out,
	output logic inta_n_out,
	output logic led_status_out,
	output logic led_sigdet_out,
	output logic led_own_out
);
	localparam int EW = rsm_pkg::ENTRY_W;
	localparam logic [27:0] MEM_TOP = (MEM_MB == 256) ? rsm_pkg::MEM_TOP_256 : rsm_pkg::MEM_TOP_128;

	if (MEM_MB != 128 && MEM_MB != 256) begin : g_chk
		$error("rsm_node MEM_MB must be 128 or 256");
	end

	function automatic logic [EW-1:0] mk_entry(input logic [7:0] o, input logic [25:0] a,
			input logic [31:0] d);
		mk_entry = {o, a, d};
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	logic sig_det_s, sync_s, link_ok, link_ok_d_reg, id_done_reg;
	logic [7:0] node_id_reg;

	rsm_sync3 u_sd (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .pin_in(sig_det_in),
		.level_out(sig_det_s));
	rsm_sync3 u_sy (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .pin_in(sync_in),
		.level_out(sync_s));
	assign link_ok = sig_det_s && sync_s;

	// Node ID strap is sampled once after reset release.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			node_id_reg <= '0;
			id_done_reg <= 1'b0;
			link_ok_d_reg <= 1'b0;
		end else begin
			if (!id_done_reg) begin
				node_id_reg <= node_id_in;
			end
			id_done_reg <= 1'b1;
			link_ok_d_reg <= link_ok;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	logic txf_wv, txf_wr, txf_rv, txf_rr, rxf_wv, rxf_wr, rxf_rv, fwd_go;
	logic [EW-1:0] txf_wd, txf_rd, rxf_wd, rxf_rd;
	logic take, shm, in_win, host_push, ack_reg, rd_wait_reg;
	logic [31:0] interrupt_control_state_reg, secondary_irq_status_reg, secondary_irq_enable_reg;
	logic led_reg, lint_n_reg;

	rsm_fifo #(.W(EW), .D(TXF_DEPTH)) u_txf (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.wr_valid_in(txf_wv), .wr_ready_out(txf_wr), .wr_data_in(txf_wd),
		.rd_valid_out(txf_rv), .rd_ready_in(txf_rr), .rd_data_out(txf_rd));
	rsm_fifo #(.W(EW), .D(RXF_DEPTH)) u_rxf (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.wr_valid_in(rxf_wv), .wr_ready_out(rxf_wr), .wr_data_in(rxf_wd),
		.rd_valid_out(rxf_rv), .rd_ready_in(fwd_go), .rd_data_out(rxf_rd));

	assign shm = (host_bar_in == rsm_pkg::BAR_SHMEM);
	assign in_win = (host_addr_in <= MEM_TOP);
	// Shared-memory writes stall while the transmit FIFO is full.
	assign take = host_req_in && !ack_reg && !rd_wait_reg && !(shm && host_wr_in && !txf_wr);
	assign host_push = take && shm && host_wr_in && in_win;
	// Forwarding yields the SDRAM port to any host shared-memory access in the same cycle.
	assign fwd_go = rxf_rv && txf_wr && !(take && shm);
	assign txf_wv = host_push || fwd_go;
	assign txf_wd = host_push ? mk_entry(node_id_reg, host_addr_in[27:2], host_wdata_in)
		: rxf_rd;

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sdram_wr_out <= 1'b0;
			sdram_addr_out <= '0;
			sdram_wdata_out <= '0;
		end else begin
			sdram_wr_out <= host_push || fwd_go;
			if (host_push) begin
				sdram_addr_out <= host_addr_in[27:2];
				sdram_wdata_out <= host_wdata_in;
			end else if (fwd_go) begin
				sdram_addr_out <= rxf_rd[57:32];
				sdram_wdata_out <= rxf_rd[31:0];
			end else if (take && shm) begin
				sdram_addr_out <= host_addr_in[27:2];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	function automatic logic hit(input logic [1:0] bar, input logic [7:0] ofs);
		hit = (host_addr_in[27:8] == '0) && (host_addr_in[7:0] == ofs) &&
			((bar == rsm_pkg::BAR_NODE) ? (host_bar_in == bar)
			: (host_bar_in == rsm_pkg::BAR_LCFG_MEM || host_bar_in == rsm_pkg::BAR_LCFG_IO));
	endfunction

	logic wr_ic, wr_lc, wr_ls, wr_le;
	logic [31:0] rd_mux, secondary_irq_status_set, local_ctrl_status_first;
	logic own_evt, rxerr_evt;

	assign wr_ic = take && host_wr_in && hit(rsm_pkg::BAR_LCFG_MEM, rsm_pkg::OFS_INTERRUPT_CONTROL_STATE);
	assign wr_lc = take && host_wr_in && hit(rsm_pkg::BAR_NODE, rsm_pkg::OFS_LOCAL_CTRL_STATUS_FIRST);
	assign wr_ls = take && host_wr_in && hit(rsm_pkg::BAR_NODE, rsm_pkg::OFS_SECONDARY_IRQ_STATUS);
	assign wr_le = take && host_wr_in && hit(rsm_pkg::BAR_NODE, rsm_pkg::OFS_SECONDARY_IRQ_ENABLE);
	assign local_ctrl_status_first = {led_reg, 28'h0, link_ok, sync_s, sig_det_s};

	always_comb begin
		rd_mux = 32'h0;
		if (hit(rsm_pkg::BAR_LCFG_MEM, rsm_pkg::OFS_INTERRUPT_CONTROL_STATE)) begin
			rd_mux = interrupt_control_state_reg;
			rd_mux[rsm_pkg::IC_LINT_ACT] = !lint_n_reg;
		end else if (hit(rsm_pkg::BAR_NODE, rsm_pkg::OFS_NODE_ID)) begin
			rd_mux = {24'h0, node_id_reg};
		end else if (hit(rsm_pkg::BAR_NODE, rsm_pkg::OFS_LOCAL_CTRL_STATUS_FIRST)) begin
			rd_mux = local_ctrl_status_first;
		end else if (hit(rsm_pkg::BAR_NODE, rsm_pkg::OFS_SECONDARY_IRQ_STATUS)) begin
			rd_mux = secondary_irq_status_reg;
		end else if (hit(rsm_pkg::BAR_NODE, rsm_pkg::OFS_SECONDARY_IRQ_ENABLE)) begin
			rd_mux = secondary_irq_enable_reg;
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack_reg <= 1'b0;
			rd_wait_reg <= 1'b0;
			sdram_rd_out <= 1'b0;
			host_rdata_out <= '0;
		end else begin
			ack_reg <= 1'b0;
			sdram_rd_out <= take && shm && !host_wr_in && in_win;
			rd_wait_reg <= take && shm && !host_wr_in && in_win;
			if (rd_wait_reg) begin
				ack_reg <= 1'b1;
				host_rdata_out <= sdram_rdata_in;
			end else if (take && !(shm && !host_wr_in && in_win)) begin
				ack_reg <= 1'b1;
				host_rdata_out <= host_wr_in ? 32'h0 : rd_mux;
			end
		end
	end
	assign host_ack_out = ack_reg;

	//////////////////////////////////////////////////////////////////////////////
	assign secondary_irq_status_set = (32'(own_evt) << rsm_pkg::LI_OWN) | (32'(rxerr_evt) << rsm_pkg::LI_RXERR)
		| (32'(link_ok_d_reg && !link_ok) << rsm_pkg::LI_LINKDN)
		| (32'(net_irq_in) << rsm_pkg::LI_NET_LSB);

	// Status bits clear on write-one; a new event in the same cycle wins.
	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			secondary_irq_status_reg <= rsm_pkg::SECONDARY_IRQ_STATUS_RST;
			secondary_irq_enable_reg <= rsm_pkg::SECONDARY_IRQ_ENABLE_RST;
			interrupt_control_state_reg <= rsm_pkg::INTERRUPT_CONTROL_STATE_RST;
			led_reg <= rsm_pkg::LED_RST;
			lint_n_reg <= 1'b1;
			inta_n_out <= 1'b1;
		end else begin
			secondary_irq_status_reg <= ((secondary_irq_status_reg & ~(wr_ls ? host_wdata_in : 32'h0)) | secondary_irq_status_set)
				& rsm_pkg::SECONDARY_IRQ_STATUS_USED;
			if (wr_le) begin
				secondary_irq_enable_reg <= host_wdata_in & rsm_pkg::SECONDARY_IRQ_STATUS_USED;
			end
			if (wr_lc) begin
				led_reg <= host_wdata_in[rsm_pkg::LC_LED];
			end
			if (wr_ic) begin
				interrupt_control_state_reg <= (host_wdata_in & rsm_pkg::INTERRUPT_CONTROL_STATE_WMASK)
					| (interrupt_control_state_reg & ~rsm_pkg::INTERRUPT_CONTROL_STATE_WMASK);
				if (host_wdata_in[rsm_pkg::IC_DMA_DONE]) begin
					interrupt_control_state_reg[rsm_pkg::IC_DMA_DONE] <= 1'b0;
				end
			end
			if (dma_done_in) begin
				interrupt_control_state_reg[rsm_pkg::IC_DMA_DONE] <= 1'b1;
			end
			lint_n_reg <= !(|(secondary_irq_status_reg & secondary_irq_enable_reg));
			inta_n_out <= !(interrupt_control_state_reg[rsm_pkg::IC_PCI_EN] &&
				((interrupt_control_state_reg[rsm_pkg::IC_LINT_EN] && !lint_n_reg) ||
				(interrupt_control_state_reg[rsm_pkg::IC_DMA_EN] && interrupt_control_state_reg[rsm_pkg::IC_DMA_DONE])));
		end
	end

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			led_status_out <= rsm_pkg::LED_RST;
			led_sigdet_out <= 1'b0;
			led_own_out <= 1'b0;
		end else begin
			led_status_out <= led_reg;
			led_sigdet_out <= sig_det_s;
			led_own_out <= secondary_irq_status_reg[rsm_pkg::LI_OWN] | own_evt;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	rsm_pkg::rsm_tx_state_t ts_reg;
	logic [31:0] tbuf_reg [rsm_pkg::PKT_MAX_WORDS];
	logic [7:0] t_orig_reg;
	logic [25:0] t_addr_reg;
	logic [4:0] t_n_reg, t_i_reg;
	logic [31:0] t_chk_reg;
	logic out_free, t_match;

	assign out_free = !tx_valid_out || tx_ready_in;
	assign t_match = txf_rv && (txf_rd[65:58] == t_orig_reg) && (t_n_reg != 5'd16)
		&& (txf_rd[57:32] == t_addr_reg + 26'(t_n_reg));
	assign txf_rr = ((ts_reg == rsm_pkg::T_IDLE) && link_ok) ||
		((ts_reg == rsm_pkg::T_GATHER) && t_match && link_ok);

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ts_reg <= rsm_pkg::T_IDLE;
			t_orig_reg <= '0;
			t_addr_reg <= '0;
			t_n_reg <= '0;
			t_i_reg <= '0;
			t_chk_reg <= '0;
			tx_valid_out <= 1'b0;
			tx_sop_out <= 1'b0;
			tx_eop_out <= 1'b0;
			tx_data_out <= '0;
		end else if (!link_ok) begin
			ts_reg <= rsm_pkg::T_IDLE;
			tx_valid_out <= 1'b0;
		end else begin
			if (tx_ready_in) begin
				tx_valid_out <= 1'b0;
			end
			case (ts_reg)
				rsm_pkg::T_IDLE: begin
					if (txf_rv) begin
						t_orig_reg <= txf_rd[65:58];
						t_addr_reg <= txf_rd[57:32];
						tbuf_reg[0] <= txf_rd[31:0];
						t_n_reg <= 5'd1;
						ts_reg <= rsm_pkg::T_GATHER;
					end
				end
				rsm_pkg::T_GATHER: begin
					if (t_match) begin
						tbuf_reg[t_n_reg[3:0]] <= txf_rd[31:0];
						t_n_reg <= t_n_reg + 5'd1;
					end else begin
						ts_reg <= rsm_pkg::T_HDR0;
					end
				end
				rsm_pkg::T_HDR0: begin
					if (out_free) begin
						tx_valid_out <= 1'b1;
						tx_sop_out <= 1'b1;
						tx_eop_out <= 1'b0;
						tx_data_out <= {t_orig_reg, 20'h0, 4'(t_n_reg - 5'd1)};
						t_chk_reg <= {t_orig_reg, 20'h0, 4'(t_n_reg - 5'd1)};
						ts_reg <= rsm_pkg::T_HDR1;
					end
				end
				rsm_pkg::T_HDR1: begin
					if (out_free) begin
						tx_valid_out <= 1'b1;
						tx_sop_out <= 1'b0;
						tx_data_out <= {6'h0, t_addr_reg};
						t_chk_reg <= t_chk_reg ^ {6'h0, t_addr_reg};
						t_i_reg <= '0;
						ts_reg <= rsm_pkg::T_DATA;
					end
				end
				rsm_pkg::T_DATA: begin
					if (out_free) begin
						tx_valid_out <= 1'b1;
						tx_data_out <= tbuf_reg[t_i_reg[3:0]];
						t_chk_reg <= t_chk_reg ^ tbuf_reg[t_i_reg[3:0]];
						t_i_reg <= t_i_reg + 5'd1;
						if (t_i_reg + 5'd1 == t_n_reg) begin
							ts_reg <= rsm_pkg::T_CHK;
						end
					end
				end
				rsm_pkg::T_CHK: begin
					if (out_free) begin
						tx_valid_out <= 1'b1;
						tx_eop_out <= 1'b1;
						tx_data_out <= t_chk_reg;
						ts_reg <= rsm_pkg::T_IDLE;
					end
				end
				default: ts_reg <= rsm_pkg::T_IDLE;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	rsm_pkg::rsm_rx_state_t rs_reg;
	logic [31:0] rbuf_reg [rsm_pkg::PKT_MAX_WORDS];
	logic [7:0] r_orig_reg;
	logic [3:0] r_len_reg;
	logic [25:0] r_addr_reg;
	logic [4:0] r_n_reg, r_i_reg;
	logic [31:0] r_chk_reg;
	logic r_good, r_take;

	assign r_take = rx_valid_in && rx_ready_out;
	assign r_good = (rx_data_in == r_chk_reg) && (r_n_reg == 5'(r_len_reg) + 5'd1);
	assign own_evt = r_take && rx_eop_in && rs_reg == rsm_pkg::R_DATA && r_good
		&& r_orig_reg == node_id_reg;
	assign rxerr_evt = r_take && ((rx_sop_in && rs_reg != rsm_pkg::R_IDLE) ||
		(rx_eop_in && (rs_reg != rsm_pkg::R_DATA || !r_good)) ||
		(rs_reg == rsm_pkg::R_DATA && !rx_eop_in && r_n_reg == 5'd16));
	assign rxf_wv = (rs_reg == rsm_pkg::R_DRAIN);
	assign rxf_wd = mk_entry(r_orig_reg, r_addr_reg + 26'(r_i_reg), rbuf_reg[r_i_reg[3:0]]);

	always_ff @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rs_reg <= rsm_pkg::R_IDLE;
			rx_ready_out <= 1'b1;
			r_orig_reg <= '0;
			r_len_reg <= '0;
			r_addr_reg <= '0;
			r_n_reg <= '0;
			r_i_reg <= '0;
			r_chk_reg <= '0;
		end else if (rxerr_evt) begin
			rs_reg <= rsm_pkg::R_IDLE;
		end else begin
			case (rs_reg)
				rsm_pkg::R_IDLE: begin
					if (r_take && rx_sop_in) begin
						r_orig_reg <= rx_data_in[31:24];
						r_len_reg <= rx_data_in[3:0];
						r_chk_reg <= rx_data_in;
						rs_reg <= rsm_pkg::R_HDR1;
					end
				end
				rsm_pkg::R_HDR1: begin
					if (r_take) begin
						r_addr_reg <= rx_data_in[25:0];
						r_chk_reg <= r_chk_reg ^ rx_data_in;
						r_n_reg <= '0;
						rs_reg <= rsm_pkg::R_DATA;
					end
				end
				rsm_pkg::R_DATA: begin
					if (r_take && rx_eop_in) begin
						r_i_reg <= '0;
						if (r_orig_reg == node_id_reg) begin
							rs_reg <= rsm_pkg::R_IDLE;
						end else begin
							rs_reg <= rsm_pkg::R_DRAIN;
							rx_ready_out <= 1'b0;
						end
					end else if (r_take) begin
						rbuf_reg[r_n_reg[3:0]] <= rx_data_in;
						r_chk_reg <= r_chk_reg ^ rx_data_in;
						r_n_reg <= r_n_reg + 5'd1;
					end
				end
				rsm_pkg::R_DRAIN: begin
					if (rxf_wr) begin
						r_i_reg <= r_i_reg + 5'd1;
						if (r_i_reg + 5'd1 == r_n_reg) begin
							rs_reg <= rsm_pkg::R_IDLE;
							rx_ready_out <= 1'b1;
						end
					end
				end
				default: rs_reg <= rsm_pkg::R_IDLE;
			endcase
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	sequence shm_write_taken;
		take && shm && host_wr_in && in_win;
	endsequence
	sequence sdram_and_queue;
		sdram_wr_out && sdram_addr_out == $past(host_addr_in[27:2]);
	endsequence

	host_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		shm_write_taken |-> txf_wv && txf_wd[65:58] == node_id_reg ##1 sdram_and_queue)
		else $error("host shared write not queued and stored");
	tx_suppress_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!link_ok |=> !tx_valid_out) else $error("transmit while link down");
	pkt_length_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		ts_reg == rsm_pkg::T_HDR0 |-> t_n_reg >= 5'd1 && t_n_reg <= 5'd16)
		else $error("packet length outside 1..16 words");
	own_drop_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		own_evt |=> rs_reg == rsm_pkg::R_IDLE && !rxf_wv ##1 led_own_out)
		else $error("own packet not dropped");
	bad_pkt_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		rxerr_evt |=> rs_reg == rsm_pkg::R_IDLE ##0 secondary_irq_status_reg[rsm_pkg::LI_RXERR])
		else $error("bad packet not discarded");
	led_boot_a: assert property (@(posedge mclk_in)
		$rose(rst_n_in) |-> led_status_out) else $error("status LED off after reset");
	led_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		wr_lc |-> ##2 led_status_out == $past(host_wdata_in[31], 2))
		else $error("status LED ignores control write");
	net_irq_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		net_irq_in[0] && secondary_irq_enable_reg[rsm_pkg::LI_NET_LSB] && !wr_le && !wr_ic
		&& interrupt_control_state_reg[rsm_pkg::IC_PCI_EN] && interrupt_control_state_reg[rsm_pkg::IC_LINT_EN] |-> ##3 !inta_n_out)
		else $error("enabled network interrupt not raised");
	inta_level_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!interrupt_control_state_reg[rsm_pkg::IC_PCI_EN] && !wr_ic |=> inta_n_out)
		else $error("interrupt asserted while disabled");
endmodule

/* File: dv/rsm_link_peer.sv */
// Ring neighbour model: takes sent words, sends packets on demand.
`timescale 1ns/1ps
module rsm_link_peer (
	input wire logic mclk_in,
	input wire logic slow_in,
	input wire logic tx_valid_in,
	input wire logic [31:0] tx_data_in,
	input wire logic tx_sop_in,
	input wire logic tx_eop_in,
	output logic tx_ready_out,
	output logic rx_valid_out,
	output logic rx_sop_out,
	output logic rx_eop_out,
	output logic [31:0] rx_data_out,
	input wire logic rx_ready_in
);
	logic [31:0] txq[$];
	logic [1:0] flq[$];
	initial begin
		tx_ready_out = 1'b0;
		rx_valid_out = 1'b0;
		rx_sop_out = 1'b0;
		rx_eop_out = 1'b0;
		rx_data_out = 32'h0;
	end
	// Slow mode stalls every other cycle to exercise held words.
	always @(negedge mclk_in) begin
		tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
	end
	always @(posedge mclk_in) begin
		if (tx_valid_in && tx_ready_out) begin
			txq.push_back(tx_data_in);
			flq.push_back({tx_sop_in, tx_eop_in});
		end
	end
	task automatic send(input logic [31:0] w[4]);
		for (int i = 0; i < 4; i++) begin
			rx_valid_out = 1'b1;
			rx_sop_out = (i == 0);
			rx_eop_out = (i == 3);
			rx_data_out = w[i];
			do @(posedge mclk_in); while (rx_ready_in !== 1'b1);
			@(negedge mclk_in);
		end
		rx_valid_out = 1'b0;
		rx_sop_out = 1'b0;
		rx_eop_out = 1'b0;
		// A released line must not keep showing the last word.
		rx_data_out = ~rx_data_out;
		@(negedge mclk_in);
	endtask
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the ring node.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
	$display("unexpected %0t: %h /= %h", $time, (a), (b)); end end
module testbench;
	typedef logic [31:0] rsm_pkt_t [4];
	localparam logic [7:0] ME = 8'h21;
	localparam logic [7:0] PEER = 8'h05;
	logic mclk_in = 1'b0, rst_n_in = 1'b0, host_req_in = 1'b0, host_wr_in = 1'b0;
	logic host_dma_in = 1'b0, dma_done_in = 1'b0, sig_det_in = 1'b0, sync_in = 1'b0;
	logic slow = 1'b0;
	logic [1:0] host_bar_in = 2'h0;
	logic [27:0] host_addr_in = 28'h0;
	logic [31:0] host_wdata_in = 32'h0, sdram_rdata_in = 32'h0, r, wd;
	logic [4:0] net_irq_in = 5'h0;
	logic [7:0] node_id_in = ME;
	logic host_ack_out, sdram_wr_out, sdram_rd_out, tx_valid_out, tx_sop_out, tx_eop_out;
	logic tx_ready_in, rx_valid_in, rx_sop_in, rx_eop_in, rx_ready_out, inta_n_out;
	logic led_status_out, led_sigdet_out, led_own_out;
	logic [31:0] host_rdata_out, sdram_wdata_out, tx_data_out, rx_data_in;
	logic [25:0] sdram_addr_out, wa;
	rsm_pkt_t e;
	int fail_count = 0, total_checks = 0, wr_cnt = 0, n;
	always #25 mclk_in = ~mclk_in;
	// Memory model answers while the read strobe stands, else scrambles.
	always @(negedge mclk_in) begin
		if (sdram_rd_out === 1'b1)
			sdram_rdata_in = {6'h0, sdram_addr_out} ^ 32'h5a5a0000;
		else
			sdram_rdata_in = ~sdram_rdata_in;
	end
	always @(posedge mclk_in) begin
		if (sdram_wr_out === 1'b1) begin
			wr_cnt++;
			wa <= sdram_addr_out;
			wd <= sdram_wdata_out;
		end
	end
	rsm_node #(.MEM_MB(128), .TXF_DEPTH(4), .RXF_DEPTH(4)) u_dut (.mclk_in, .rst_n_in,
		.node_id_in, .host_req_in, .host_bar_in, .host_wr_in, .host_dma_in, .host_addr_in,
		.host_wdata_in, .host_ack_out, .host_rdata_out, .dma_done_in, .net_irq_in,
		.sdram_wr_out, .sdram_rd_out, .sdram_addr_out, .sdram_wdata_out, .sdram_rdata_in,
		.sig_det_in, .sync_in, .tx_valid_out, .tx_sop_out, .tx_eop_out, .tx_data_out,
		.tx_ready_in, .rx_valid_in, .rx_sop_in, .rx_eop_in, .rx_data_in, .rx_ready_out,
		.inta_n_out, .led_status_out, .led_sigdet_out, .led_own_out);
	rsm_link_peer p (.mclk_in, .slow_in(slow), .tx_valid_in(tx_valid_out),
		.tx_sop_in(tx_sop_out), .tx_eop_in(tx_eop_out),
		.tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in), .rx_valid_out(rx_valid_in),
		.rx_sop_out(rx_sop_in), .rx_eop_out(rx_eop_in), .rx_data_out(rx_data_in),
		.rx_ready_in(rx_ready_out));
	function automatic rsm_pkt_t pk(input logic [7:0] o, input logic [25:0] a,
		input logic [31:0] d);
		pk[0] = {o, 24'h0};
		pk[1] = {6'h0, a};
		pk[2] = d;
		pk[3] = pk[0] ^ pk[1] ^ d;
	endfunction
	task automatic acc(input logic [1:0] b, input logic w, input logic [27:0] a,
		input logic [31:0] d);
		int k;
		k = 0;
		host_req_in = 1'b1;
		host_bar_in = b;
		host_wr_in = w;
		host_addr_in = a;
		host_wdata_in = d;
		do begin @(posedge mclk_in); k++; end while (host_ack_out !== 1'b1 && k < 40);
		r = host_rdata_out;
		`CHK(host_ack_out, 1'b1)
		@(negedge mclk_in);
		host_req_in = 1'b0;
		@(negedge mclk_in);
	endtask
	task automatic cyc(input int c);
		repeat (c) @(negedge mclk_in);
	endtask
	task automatic chkq(input rsm_pkt_t x);
		for (int k = 0; k < 100 && p.txq.size() < 4; k++) cyc(1);
		for (int i = 0; i < 4; i++) `CHK(p.txq[i], x[i])
		`CHK({p.flq[0], p.flq[1], p.flq[2], p.flq[3]}, 8'h81)
		p.txq.delete();
		p.flq.delete();
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		cyc(12);
		rst_n_in = 1'b1;
		cyc(3);
		`CHK(led_status_out, 1'b1)
		acc(2'h2, 1'b1, 28'h08, 32'h0);
		`CHK(led_status_out, 1'b0)
		acc(2'h2, 1'b1, 28'h08, 32'h80000000);
		`CHK(led_status_out, 1'b1)
		acc(2'h2, 1'b0, 28'h40, 32'h0);
		`CHK(r, 32'h0)
		acc(2'h2, 1'b0, 28'h04, 32'h0);
		`CHK(r, {24'h0, ME})
		$display("test regs done");
		acc(2'h3, 1'b1, 28'h0, 32'h11);
		`CHK(wr_cnt, 1)
		`CHK(wa, 26'h0)
		cyc(20);
		`CHK(p.txq.size(), 0)
		sig_det_in = 1'b1;
		sync_in = 1'b1;
		cyc(40);
		`CHK(led_sigdet_out, 1'b1)
		p.txq.delete();
		p.flq.delete();
		slow = 1'b1;
		host_dma_in = 1'b1;
		acc(2'h3, 1'b1, 28'h200, 32'hcafe0001);
		host_dma_in = 1'b0;
		`CHK(wd, 32'hcafe0001)
		chkq(pk(ME, 26'h80, 32'hcafe0001));
		slow = 1'b0;
		$display("test send done");
		p.send(pk(PEER, 26'h40, 32'h12345678));
		cyc(30);
		`CHK({wa, wd}, {26'h40, 32'h12345678})
		chkq(pk(PEER, 26'h40, 32'h12345678));
		e = pk(PEER, 26'h50, 32'h9);
		e[3] = e[3] ^ 32'h1;
		n = wr_cnt;
		p.send(e);
		p.send(pk(ME, 26'h60, 32'h7));
		cyc(30);
		`CHK(wr_cnt, n)
		`CHK(p.txq.size(), 0)
		`CHK(led_own_out, 1'b1)
		acc(2'h2, 1'b0, 28'h10, 32'h0);
		`CHK({r[2], r[0]}, 2'h3)
		$display("test receive done");
		acc(2'h2, 1'b1, 28'h10, 32'hffffffff);
		acc(2'h2, 1'b1, 28'h14, 32'h100);
		acc(2'h2, 1'b0, 28'h14, 32'h0);
		`CHK(r, 32'h100)
		acc(2'h0, 1'b1, 28'h68, 32'h800);
		net_irq_in = 5'h1;
		cyc(1);
		net_irq_in = 5'h0;
		cyc(4);
		`CHK(inta_n_out, 1'b1)
		acc(2'h0, 1'b1, 28'h68, 32'h900);
		cyc(3);
		`CHK(inta_n_out, 1'b0)
		acc(2'h1, 1'b0, 28'h68, 32'h0);
		`CHK(r[15], 1'b1)
		acc(2'h2, 1'b1, 28'h10, 32'h100);
		cyc(3);
		`CHK(inta_n_out, 1'b1)
		net_irq_in = 5'h1;
		cyc(1);
		net_irq_in = 5'h0;
		cyc(3);
		`CHK(inta_n_out, 1'b0)
		acc(2'h2, 1'b1, 28'h10, 32'h100);
		cyc(3);
		`CHK(inta_n_out, 1'b1)
		acc(2'h0, 1'b1, 28'h68, 32'h40900);
		dma_done_in = 1'b1;
		cyc(1);
		dma_done_in = 1'b0;
		cyc(3);
		`CHK(inta_n_out, 1'b0)
		acc(2'h0, 1'b0, 28'h68, 32'h0);
		`CHK(r[21], 1'b1)
		acc(2'h1, 1'b1, 28'h68, 32'h240900);
		cyc(3);
		`CHK(inta_n_out, 1'b1)
		$display("test irq done");
		acc(2'h3, 1'b0, 28'h200, 32'h0);
		`CHK(r, 32'h5a5a0080)
		acc(2'h3, 1'b0, 28'h8000000, 32'h0);
		`CHK(r, 32'h0)
		$display("test memory done");
		final_report;
	end
	initial begin
		#1000000;
		fail_count++;
		final_report;
	end
endmodule
